/* rvr_readout.sv */
// reference value readout: parses request bytes, streams the reply
// assumes request and reply bytes are framed by a link layer on core_clk_i
`include "rvr_regs.svh"
module rvr_readout (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // calibration values, unsigned 16.16, held stable by the owner
  input wire logic [31:0] left_gain_i,
  input wire logic [31:0] right_gain_i,
  input wire logic [31:0] left_offset_i,
  input wire logic [31:0] right_offset_i,
  // request byte stream
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  // reply byte stream
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  output logic busy_o
);
  // parser and reply sequencer share one one-hot state register
  rvr_pkg::rvr_state_t state_ff;
  rvr_pkg::rvr_state_t nxt_state;
  logic match_ff;
  logic nxt_match;
  // values frozen at accept, left gain in the low word
  logic [127:0] snap_ff;
  logic [127:0] nxt_snap;
  // reply byte now shown, header counted: 18 is the last data byte
  logic [4:0] pos_ff;
  logic [4:0] nxt_pos;
  logic tx_valid_ff;
  logic nxt_tx_valid;
  logic [7:0] tx_byte_ff;
  logic [7:0] nxt_tx_byte;
  logic busy_ff;
  logic nxt_busy;

  // decoded request bytes and reply handshake
  logic code_hit;
  logic flag_read;
  logic len_hit;
  logic accept;
  logic in_reply;
  logic take;
  logic last_take;
  logic [4:0] pos_inc;
  logic [7:0] pick_byte;
  logic [7:0] lane [16];

  // lane 0 is the low fraction byte of left gain
  for (genvar g = 0; g < 16; g++) begin : g_lane
    assign lane[g] = snap_ff[8 * g +: 8]; // R02 R03
  end

  // request byte decode, one byte per rx_valid_i
  assign code_hit = (rx_byte_i == `RVR_CMD_CODE); // R01
  assign flag_read = (rx_byte_i[`RVR_FLAG_BIT] == `RVR_FLAG_READ); // R07
  // other length values are refused, never truncated
  assign len_hit = (rx_byte_i == `RVR_DATA_LEN); // R01
  assign accept = (state_ff == rvr_pkg::RVR_LEN) && rx_valid_i &&
                  match_ff && len_hit;
  assign in_reply = (state_ff == rvr_pkg::RVR_HDR) ||
                    (state_ff == rvr_pkg::RVR_DATA);
  assign take = tx_valid_ff && tx_ready_i && in_reply;
  assign last_take = take && (pos_ff == `RVR_LAST_POS);
  assign pos_inc = pos_ff + 5'h01;

  // one byte of lookahead, so the next byte is ready when one is taken
  always_comb begin
    pick_byte = 8'h00;
    case (pos_inc)
      5'h01: pick_byte = {7'h00, `RVR_FLAG_REPLY}; // R07
      5'h02: pick_byte = `RVR_DATA_LEN; // R07
      // left gain, right gain, left offset, right offset, low byte first
      5'h03: pick_byte = lane[0]; // R03 R04
      5'h04: pick_byte = lane[1]; // R04
      5'h05: pick_byte = lane[2]; // R04
      5'h06: pick_byte = lane[3]; // R04
      5'h07: pick_byte = lane[4]; // R05
      5'h08: pick_byte = lane[5]; // R05
      5'h09: pick_byte = lane[6]; // R05
      5'h0A: pick_byte = lane[7]; // R05
      5'h0B: pick_byte = lane[8]; // R06
      5'h0C: pick_byte = lane[9]; // R06
      5'h0D: pick_byte = lane[10]; // R06
      5'h0E: pick_byte = lane[11]; // R06
      5'h0F: pick_byte = lane[12]; // R06
      5'h10: pick_byte = lane[13]; // R06
      5'h11: pick_byte = lane[14]; // R06
      5'h12: pick_byte = lane[15]; // R06
      default: begin
        pick_byte = 8'h00;
      end
    endcase
  end

  // request parser and reply phase
  always_comb begin
    nxt_state = state_ff;
    nxt_match = match_ff;
    case (state_ff)
      rvr_pkg::RVR_IDLE: begin
        if (rx_valid_i) begin
          nxt_match = code_hit;
          nxt_state = rvr_pkg::RVR_FLAG;
        end
      end
      rvr_pkg::RVR_FLAG: begin
        if (rx_valid_i) begin
          // write form is dropped silently
          nxt_match = match_ff && flag_read; // R01 R07
          nxt_state = rvr_pkg::RVR_LEN;
        end
      end
      rvr_pkg::RVR_LEN: begin
        if (accept) begin
          nxt_state = rvr_pkg::RVR_HDR;
        end else if (rx_valid_i) begin
          // three bytes consumed, no reply and no error flag
          nxt_state = rvr_pkg::RVR_IDLE;
        end
      end
      rvr_pkg::RVR_HDR: begin
        // request bytes during a reply are ignored, not buffered
        if (take && pos_inc == `RVR_FIRST_DATA_POS) begin
          nxt_state = rvr_pkg::RVR_DATA;
        end
      end
      rvr_pkg::RVR_DATA: begin
        if (last_take) begin
          nxt_state = rvr_pkg::RVR_IDLE;
        end
      end
      default: begin
        // illegal code from an upset: back to idle, reply dropped
        nxt_state = rvr_pkg::RVR_IDLE;
        nxt_match = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= rvr_pkg::RVR_IDLE;
      match_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      match_ff <= nxt_match;
    end
  end

  // snapshot so a value cannot tear mid reply
  always_comb begin
    nxt_snap = snap_ff;
    if (accept) begin
      nxt_snap = {right_offset_i, left_offset_i,
                  right_gain_i, left_gain_i}; // R02 R04 R05 R06
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      snap_ff <= 128'h0;
    end else begin
      snap_ff <= nxt_snap;
    end
  end

  // reply byte, valid and position
  always_comb begin
    nxt_pos = pos_ff;
    nxt_tx_valid = tx_valid_ff;
    nxt_tx_byte = tx_byte_ff;
    if (accept) begin
      // header leads with the echoed code
      nxt_pos = 5'h00;
      nxt_tx_valid = 1'b1;
      nxt_tx_byte = `RVR_CMD_CODE; // R07
    end else if (!in_reply) begin
      // valid cannot hang outside a reply
      nxt_tx_valid = 1'b0;
    end else if (last_take) begin
      // byte stays on the lines, valid alone drops
      nxt_tx_valid = 1'b0;
    end else if (take) begin
      nxt_pos = pos_inc;
      nxt_tx_byte = pick_byte; // R03
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_ff <= 5'h00;
      tx_valid_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
    end else begin
      pos_ff <= nxt_pos;
      tx_valid_ff <= nxt_tx_valid;
      tx_byte_ff <= nxt_tx_byte;
    end
  end

  // busy leads from the next state so it rises with valid
  always_comb begin
    nxt_busy = (nxt_state == rvr_pkg::RVR_HDR) ||
               (nxt_state == rvr_pkg::RVR_DATA);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
    end
  end

  // outputs straight from their registers
  assign tx_valid_o = tx_valid_ff;
  assign tx_byte_o = tx_byte_ff;
  assign busy_o = busy_ff;
endmodule

/* rvr_regs.svh */
// constants for the reference value readout command interpreter
// assumes a byte stream from a framing layer on the same clock
// Function
// [R01] command 0x08 is read only; answers read of length 16, no write form
// [R02] each value is unsigned 32-bit, 16 integer and 16 fraction bits
// [R03] each value sent fraction low, fraction high, integer low, integer high
// [R04] bytes one to four carry the left gain value
// [R05] bytes five to eight carry the right gain value
// [R06] bytes nine to twelve left offset, thirteen to sixteen right offset
// [R07] request has read flag one; reply echoes code, flag zero, 16 bytes
`ifndef RVR_REGS_SVH
`define RVR_REGS_SVH
`define RVR_CMD_CODE 8'h08
`define RVR_FLAG_READ 1'b1
`define RVR_FLAG_REPLY 1'b0
`define RVR_DATA_LEN 8'h10
`define RVR_FLAG_BIT 3'h0
`define RVR_FIRST_DATA_POS 5'h03
`define RVR_LAST_POS 5'h12
`endif

/* rvr_pkg.sv */
// types for the reference value readout block
// assumes nothing beyond the constants header
package rvr_pkg;
  typedef enum logic [4:0] {
    RVR_IDLE = 5'b00001,
    RVR_FLAG = 5'b00010,
    RVR_LEN  = 5'b00100,
    RVR_HDR  = 5'b01000,
    RVR_DATA = 5'b10000
  } rvr_state_t;
endpackage

/* rvr_host.sv */
// host model: sends request frames, sinks reply bytes
// assumes tb calls send and drives stall_i on core_clk_i
module rvr_host (
  input wire logic core_clk_i,
  input wire logic stall_i,
  output logic rx_valid_o = 1'b0,
  output logic [7:0] rx_byte_o = 8'h00,
  output logic tx_ready_o
);
  timeunit 1ns / 1ps;
  assign tx_ready_o = !stall_i;
  // line inverted after a frame so a stale byte cannot pass
  task automatic send(logic [23:0] req);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i) #1;
      rx_valid_o = i < 3;
      rx_byte_o = i < 3 ? req[23 - 8 * i -: 8] : ~rx_byte_o;
    end
  endtask
endmodule

/* rvr_readout_assertions.sv */
// reply stream checks for the readout block
// assumes binding to rvr_readout; n_ff counts bytes taken
module rvr_chk (
  input wire logic core_clk_i, rst_n_i, tx_ready_i, tx_valid_o, busy_o,
  input wire logic [7:0] tx_byte_o,
  input wire logic [31:0] left_gain_i, right_gain_i, right_offset_i
);
  logic [4:0] n_ff, nxt_n;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  always_comb nxt_n = tx_valid_o ? n_ff + 5'(tx_ready_i) : 5'h00;
  always_ff @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i) n_ff <= 5'h00;
    else n_ff <= nxt_n;
  chk_code_first:
    assert property ($rose(tx_valid_o) |-> tx_byte_o == 8'h08 && busy_o)
    else $error("code");
  chk_len_echo:
    assert property (n_ff == 5'h02 |-> tx_byte_o == 8'h10) else $error("len");
  chk_lgain_low:
    assert property (n_ff == 5'h03 |-> tx_byte_o == left_gain_i[7:0])
    else $error("lg");
  chk_int_high:
    assert property (n_ff == 5'h06 |-> tx_byte_o == left_gain_i[31:24])
    else $error("int");
  chk_rgain_low:
    assert property (n_ff == 5'h07 |-> tx_byte_o == right_gain_i[7:0])
    else $error("rg");
  chk_last_byte:
    assert property (n_ff == 5'h12 |-> tx_byte_o == right_offset_i[31:24])
    else $error("ro");
  chk_end_idle:
    assert property (n_ff == 5'h12 && tx_ready_i |=> !tx_valid_o && !busy_o)
    else $error("end");
  chk_flag_echo:
    assert property (n_ff == 5'h01 |-> tx_byte_o == 8'h00) else $error("flag");
  chk_byte_held:
    assert property (tx_valid_o && !tx_ready_i |=>
                     tx_valid_o && $stable(tx_byte_o))
    else $error("held");
  cover property (tx_valid_o && !tx_ready_i);
  cover property (n_ff == 5'h12 && tx_ready_i);
  cover property ($fell(busy_o));
endmodule
bind rvr_readout rvr_chk rvr_chk_i (.*);

/* tb.sv */
// bench: request rows, stalled reply, reset in mid-reply
// assumes rvr_host as request source and reply sink
module tb;
  timeunit 1ns / 1ps;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, stall_i = 1'b0;
  logic rx_valid_i, tx_ready_i, tx_valid_o, busy_o;
  logic [7:0] rx_byte_i, tx_byte_o;
  logic [31:0] left_gain_i = 32'h44332211, right_gain_i = 32'h88776655;
  logic [31:0] left_offset_i = 32'hCCBBAA99, right_offset_i = 32'h00FFEEDD;
  int fail_count = 0, n_checks = 0;
  // reply expected, then code, flag, length
  logic [24:0] rows [4] = '{25'h1080110, 25'h0080010, 25'h0080111, 25'h0090110};
  always #2.5 core_clk_i = ~core_clk_i;
  rvr_host rvr_host_i (.core_clk_i, .stall_i, .rx_valid_o(rx_valid_i),
    .rx_byte_o(rx_byte_i), .tx_ready_o(tx_ready_i));
  rvr_readout rvr_readout_i (.*);
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic collect(logic rep, logic slow);
    logic [151:0] r = {right_offset_i, left_offset_i, right_gain_i,
      left_gain_i, 24'h100008};
    int n = 0;
    // byte on the lines now is the one the next edge takes
    for (int w = 0; w < 60; w++) begin
      stall_i = slow & w[0];
      if (tx_valid_o === 1'b1 && !stall_i) begin
        cmp("byte", r[8 * n +: 8], tx_byte_o);
        cmp("busy", 8'h01, {7'h00, busy_o});
        n++;
      end
      @(posedge core_clk_i) #1;
    end
    cmp("count", rep ? 8'h13 : 8'h00, 8'(n));
    stall_i = 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    foreach (rows[i]) begin
      rvr_host_i.send(rows[i][23:0]);
      collect(rows[i][24], 1'b0);
    end
    rvr_host_i.send(24'h080110);
    collect(1'b1, 1'b1);
    rvr_host_i.send(24'h080110);
    repeat (6) @(posedge core_clk_i);
    #1 rst_n_i = 1'b0;
    #1 cmp("idle", 8'h00, {6'h00, busy_o, tx_valid_o});
    repeat (2) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    cmp("clear", 8'h00, {6'h00, busy_o, tx_valid_o});
    rvr_host_i.send(24'h080110);
    collect(1'b1, 1'b0);
    finish_test();
  end
  initial begin
    #20000;
    fail_count++;
    finish_test();
  end
endmodule
